/* File: call_gate_privilege_check.sv */
// Privilege and validity checker for far CALL and JMP, direct or through a call gate.
// Assumes the execution logic presents the referenced descriptor, its upper half and the
// destination code descriptor together with a one-cycle request, all on this clock.
//
// Overview of operation
// - Conforming target keeps level, no stack switch.
// - Selector requestor level ignored for conforming target.
// - Conforming allowed when current level >= target.
// - Direct nonconforming needs equal privilege levels.
// - Gates valid in global or local tables only.
// - Decode selector, offset, level, present, count.
// - Stack switch copies counted words or doublewords.
// - Push width follows 16 or 32-bit gate.
// - Gate present flag clear raises not-present.
// - Wide gate offset upper half, canonical check.
// - Wide gate upper type zero, else fault.
// - Wide gates copy no parameters.
// - Wide gate target must be long code.
// - Extended mode treats 0CH as wide gate.
// - Extended mode faults on 16-bit gate.
// - Wide gate pushes eight bytes, full pointer.
// - Gate found by selector; offset ignored.
// - Entry address is code base plus offset.
// - Check four levels plus conforming flag.
// - Current and requestor level within gate level.
// - Jump needs equal level; call may raise.
// - Raising call lowers level, switches stacks.
`timescale 1ns/1ps
`default_nettype none
`include "gate_check_consts.svh"

module call_gate_privilege_check (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic req_valid_in,
    input wire gate_check_pkg::check_req_s req_in,
    output var logic done_out,
    output var gate_check_pkg::check_res_s res_out
);

    function automatic logic [1:0] desc_lvl(input logic [63:0] d);
        desc_lvl = d[`DESC_LVL_HI:`DESC_LVL_LO];
    endfunction

    function automatic logic [31:0] base_of(input logic [63:0] d);
        base_of = {d[63:56], d[39:32], d[31:16]};
    endfunction

    function automatic logic is_code(input logic [63:0] d);
        is_code = d[`SYS_BIT] & d[`CODE_BIT];
    endfunction

    function automatic logic is_conforming(input logic [63:0] d);
        is_conforming = d[`CONFORM_BIT];
    endfunction

    function automatic logic is_present(input logic [63:0] d);
        is_present = d[`PRESENT_BIT];
    endfunction

    function automatic logic is_long_code(input logic [63:0] d);
        is_long_code = d[`LONG_BIT] & ~d[`DSIZE_BIT];
    endfunction

    // Bits above the sign bit must all copy it.
    function automatic logic is_canonical(input logic [63:0] off);
        is_canonical = (off[63:`CANON_MSB] == {17{off[`CANON_MSB]}});
    endfunction

    function automatic logic [63:0] gate_offset(input logic [63:0] lo_d, input logic [63:0] hi_d,
        input logic wide);
        gate_offset = wide ? {hi_d[31:0], lo_d[63:48], lo_d[15:0]}
            : {32'h0000_0000, lo_d[63:48], lo_d[15:0]};
    endfunction

    // Decoded request fields.
    logic [63:0] lo;
    logic [63:0] hi;
    logic [63:0] dest;
    logic [1:0] cur_lvl;
    logic [1:0] sel_lvl;
    logic [3:0] gate_type;
    logic is_gate;
    logic wide_gate;
    logic [15:0] gate_sel;
    logic [63:0] gate_off;

    // Check outcomes for the two kinds of transfer.
    logic direct_gp;
    logic direct_np;
    logic gate_gp;
    logic gate_np;
    logic [15:0] gate_fsel;
    logic fault_gp;
    logic fault_np;
    logic [15:0] fault_sel;
    logic accept;
    logic raise;

    // Values loaded into the result on every request; selector and entry are loaded only when it is accepted.
    logic [1:0] next_lvl;
    logic [15:0] next_cs;
    logic [63:0] next_entry;
    logic next_switch;
    logic [4:0] next_count;
    gate_check_pkg::push_size_e next_push;

    // Result registers.
    logic res_commit;
    logic res_gp;
    logic res_np;
    logic [15:0] res_fault_sel;
    logic [1:0] res_lvl;
    logic [15:0] res_code_sel;
    logic [63:0] res_entry;
    logic res_switch;
    logic [4:0] res_count;
    gate_check_pkg::push_size_e res_push;

    assign lo = req_in.desc_lo;
    assign hi = req_in.desc_hi;
    assign dest = req_in.dest_desc;
    assign cur_lvl = req_in.current_priv_level;
    assign sel_lvl = req_in.far_sel[`REQ_LVL_HI:`REQ_LVL_LO];
    assign gate_type = lo[`TYPE_HI:`TYPE_LO];
    assign is_gate = ~lo[`SYS_BIT];
    assign wide_gate = req_in.long_mode & (gate_type == `GATE32_TYPE);
    assign gate_sel = lo[`GSEL_HI:`GSEL_LO];
    assign gate_off = gate_offset(lo, hi, wide_gate);

    // Direct transfer checks; a type or level fault hides a missing segment.
    always_comb begin
        direct_gp = 1'b0;
        direct_np = 1'b0;
        if (!is_code(lo)) begin
            direct_gp = 1'b1;
        end else if (is_conforming(lo)) begin
            direct_gp = (cur_lvl < desc_lvl(lo));
        end else begin
            direct_gp = (desc_lvl(lo) != cur_lvl) || (sel_lvl > cur_lvl);
        end
        if (!direct_gp && !is_present(lo)) begin
            direct_np = 1'b1;
        end
    end

    // Gate checks in priority order; the first failing one decides the fault and its selector.
    always_comb begin
        gate_gp = 1'b0;
        gate_np = 1'b0;
        gate_fsel = req_in.far_sel;
        if (req_in.from_interrupt_table) begin
            gate_gp = 1'b1;
        end else if (req_in.long_mode && gate_type != `GATE32_TYPE) begin
            gate_gp = 1'b1;
        end else if (!req_in.long_mode && gate_type != `GATE16_TYPE && gate_type != `GATE32_TYPE) begin
            gate_gp = 1'b1;
        end else if (cur_lvl > desc_lvl(lo) || sel_lvl > desc_lvl(lo)) begin
            gate_gp = 1'b1;
        end else if (!is_present(lo)) begin
            gate_np = 1'b1;
        end else if (wide_gate && hi[`HI_TYPE_HI:`HI_TYPE_LO] != 5'h00) begin
            gate_gp = 1'b1;
        end else if (wide_gate && !is_canonical(gate_off)) begin
            gate_gp = 1'b1;
            gate_fsel = 16'h0000;
        end else if (!is_code(dest)) begin
            gate_gp = 1'b1;
            gate_fsel = gate_sel;
        end else if (wide_gate && !is_long_code(dest)) begin
            gate_gp = 1'b1;
            gate_fsel = gate_sel;
        end else if (is_conforming(dest) && desc_lvl(dest) > cur_lvl) begin
            gate_gp = 1'b1;
            gate_fsel = gate_sel;
        end else if (!is_conforming(dest) && req_in.is_call && desc_lvl(dest) > cur_lvl) begin
            gate_gp = 1'b1;
            gate_fsel = gate_sel;
        end else if (!is_conforming(dest) && !req_in.is_call && desc_lvl(dest) != cur_lvl) begin
            gate_gp = 1'b1;
            gate_fsel = gate_sel;
        end else if (!is_present(dest)) begin
            gate_np = 1'b1;
            gate_fsel = gate_sel;
        end
    end

    assign fault_gp = is_gate ? gate_gp : direct_gp;
    assign fault_np = is_gate ? gate_np : direct_np;
    assign accept = ~(fault_gp | fault_np);
    assign raise = is_gate & req_in.is_call & ~is_conforming(dest) & (desc_lvl(dest) < cur_lvl);

    always_comb begin
        fault_sel = 16'h0000;
        if (!accept) begin
            fault_sel = is_gate ? gate_fsel : req_in.far_sel;
        end
    end

    // The gate is identified by the selector alone; the pointer offset is never read for it.
    always_comb begin
        next_lvl = cur_lvl;
        next_cs = req_in.far_sel;
        next_entry = {32'h0000_0000, base_of(lo)} + req_in.far_offset;
        next_switch = 1'b0;
        next_count = 5'h00;
        next_push = gate_check_pkg::PUSH_4;
        if (is_gate) begin
            next_cs = gate_sel;
            next_entry = {32'h0000_0000, base_of(dest)} + gate_off;
            if (wide_gate) begin
                next_push = gate_check_pkg::PUSH_8;
            end else if (gate_type == `GATE16_TYPE) begin
                next_push = gate_check_pkg::PUSH_2;
            end else begin
                next_push = gate_check_pkg::PUSH_4;
            end
            if (accept && raise) begin
                next_lvl = desc_lvl(dest);
                next_switch = 1'b1;
                next_count = wide_gate ? 5'h00 : lo[`PCOUNT_HI:`PCOUNT_LO];
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done_out <= 1'b0;
        end else begin
            done_out <= req_valid_in;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            res_commit <= 1'b0;
            res_gp <= 1'b0;
            res_np <= 1'b0;
        end else if (req_valid_in) begin
            res_commit <= accept;
            res_gp <= fault_gp;
            res_np <= fault_np;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            res_fault_sel <= 16'h0000;
        end else if (req_valid_in) begin
            res_fault_sel <= fault_sel;
        end
    end

    // A fault never changes the level, since next_lvl only moves on an accepted raise.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            res_lvl <= 2'h0;
        end else if (req_valid_in) begin
            res_lvl <= next_lvl;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            res_switch <= 1'b0;
            res_count <= 5'h00;
        end else if (req_valid_in) begin
            res_switch <= next_switch;
            res_count <= next_count;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            res_push <= gate_check_pkg::PUSH_4;
        end else if (req_valid_in) begin
            res_push <= next_push;
        end
    end

    // Selector and entry keep their old values when the transfer is refused.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            res_code_sel <= 16'h0000;
            res_entry <= 64'h0000_0000_0000_0000;
        end else if (req_valid_in && accept) begin
            res_code_sel <= next_cs;
            res_entry <= next_entry;
        end
    end

    assign res_out = '{res_commit, res_gp, res_np, res_fault_sel, res_lvl, res_code_sel, res_entry,
        res_switch, res_count, res_push};

endmodule

`default_nettype wire

/* File: gate_check_consts.svh */
// Constants for the far-transfer privilege checker: descriptor field positions and type codes.
// Assumes 8-byte descriptor images, with byte 0 of the descriptor in bits 7:0.
`ifndef GATE_CHECK_CONSTS_SVH
`define GATE_CHECK_CONSTS_SVH

`define TYPE_LO 40
`define TYPE_HI 43
`define SYS_BIT 44
`define DESC_LVL_LO 45
`define DESC_LVL_HI 46
`define PRESENT_BIT 47
`define CODE_BIT 43
`define CONFORM_BIT 42
`define LONG_BIT 53
`define DSIZE_BIT 54
`define PCOUNT_LO 32
`define PCOUNT_HI 36
`define GSEL_LO 16
`define GSEL_HI 31
`define HI_TYPE_LO 40
`define HI_TYPE_HI 44
`define CANON_MSB 47
`define GATE16_TYPE 4'h4
`define GATE32_TYPE 4'hc
`define REQ_LVL_LO 0
`define REQ_LVL_HI 1
`define TI_BIT 2

`endif

/* File: gate_check_pkg.sv */
// Types shared by the far-transfer privilege checker and its users.
// Assumes the execution logic fetches every descriptor before it issues a check.
package gate_check_pkg;

    typedef enum logic [1:0] {
        PUSH_2,
        PUSH_4,
        PUSH_8
    } push_size_e;

    typedef struct packed {
        logic is_call;
        logic long_mode;
        logic [1:0] current_priv_level;
        logic [15:0] far_sel;
        logic [63:0] far_offset;
        logic from_interrupt_table;
        logic [63:0] desc_lo;
        logic [63:0] desc_hi;
        logic [63:0] dest_desc;
    } check_req_s;

    typedef struct packed {
        logic commit;
        logic general_protection_fault;
        logic not_present_fault;
        logic [15:0] fault_sel;
        logic [1:0] current_priv_level;
        logic [15:0] code_sel;
        logic [63:0] entry_addr;
        logic stack_switch;
        logic [4:0] param_count;
        push_size_e push_size;
    } check_res_s;

endpackage

/* File: gate_requester.sv */
// Requester model: issues one far-transfer check per go pulse.
// Assumes go_in is raised for one cycle at a falling edge.
`timescale 1ns/1ps
`default_nettype none
module gate_requester (
    input wire logic mclk_in,
    input wire logic go_in,
    input wire gate_check_pkg::check_req_s req_in,
    output logic req_valid_out = 1'b0,
    output gate_check_pkg::check_req_s req_out = '0
);
    // Between requests the lines show the inverse, so a stale sample cannot pass.
    always_ff @(negedge mclk_in) begin
        req_valid_out <= go_in;
        req_out <= go_in ? req_in : ~req_in;
    end
endmodule
`default_nettype wire

/* File: call_gate_privilege_check_asserts.sv */
// Checker for the far-transfer privilege checker, bound to its ports.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module call_gate_privilege_check_asserts (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic req_valid_in,
    input wire gate_check_pkg::check_req_s req_in,
    input wire logic done_out,
    input wire gate_check_pkg::check_res_s res_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);
    logic gate;
    logic fault;
    logic [1:0] lvl;
    assign gate = req_valid_in & ~req_in.desc_lo[44];
    assign fault = res_out.general_protection_fault | res_out.not_present_fault;
    assign lvl = res_out.current_priv_level;
    property p_answer; 1'b1 |=> done_out == $past(req_valid_in); endproperty
    a_answer: assert property (p_answer) else $error("done_out not one cycle after request");
    property p_fault; done_out && fault |-> !res_out.commit && lvl == $past(req_in.current_priv_level); endproperty
    a_fault: assert property (p_fault) else $error("fault changed level");
    property p_keep;
        done_out && res_out.commit && !res_out.stack_switch |-> lvl == $past(req_in.current_priv_level);
    endproperty
    a_keep: assert property (p_keep) else $error("level changed without stack switch");
    property p_raise;
        done_out && res_out.stack_switch |-> $past(req_in.is_call) && lvl < $past(req_in.current_priv_level);
    endproperty
    a_raise: assert property (p_raise) else $error("bad stack switch");
    property p_table; gate && req_in.from_interrupt_table |=> res_out.general_protection_fault; endproperty
    a_table: assert property (p_table) else $error("gate in interrupt table accepted");
    property p_g16; gate && req_in.long_mode && req_in.desc_lo[43:40] == 4'h4 |=> res_out.general_protection_fault;
    endproperty
    a_g16: assert property (p_g16) else $error("narrow gate accepted in wide mode");
    property p_glvl; gate && req_in.current_priv_level > req_in.desc_lo[46:45] |=> res_out.general_protection_fault;
    endproperty
    a_glvl: assert property (p_glvl) else $error("gate level not enforced");
    property p_wide;
        done_out && res_out.push_size == gate_check_pkg::PUSH_8 |-> res_out.param_count == 5'h0;
    endproperty
    a_wide: assert property (p_wide) else $error("wide gate copies parameters");
endmodule
bind call_gate_privilege_check call_gate_privilege_check_asserts chk_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .req_valid_in(req_valid_in), .req_in(req_in), .done_out(done_out), .res_out(res_out));
`default_nettype wire

/* File: call_gate_privilege_check_bench.sv */
// Bench for the far-transfer privilege checker: directed transfers with expected outcomes.
// Assumes the requester model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module call_gate_privilege_check_bench;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic go = 1'b0;
    logic req_valid;
    logic done;
    gate_check_pkg::check_req_s req = '0;
    gate_check_pkg::check_req_s dreq;
    gate_check_pkg::check_res_s res;
    int error_cnt = 0;
    int checks = 0;
    always #12.5 mclk_in = ~mclk_in;
    gate_requester req_u (.mclk_in(mclk_in), .go_in(go), .req_in(req), .req_valid_out(req_valid), .req_out(dreq));
    call_gate_privilege_check dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid),
        .req_in(dreq), .done_out(done), .res_out(res));
    // Code descriptor, base 1000h, present and readable.
    function automatic logic [63:0] code(input logic [1:0] lvl, input logic conf, input logic lng);
        code = 64'h0000_9a00_1000_0000 | (64'(lvl) << 45) | (64'(conf) << 42) | (64'(lng) << 53);
    endfunction
    // Gate to selector 28h, offset 340h, five parameters.
    function automatic logic [63:0] gate(input logic [3:0] typ, input logic [1:0] lvl, input logic p);
        gate = 64'h0000_0005_0028_0340 | (64'(typ) << 40) | (64'(lvl) << 45) | (64'(p) << 47);
    endfunction
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Mode is {interrupt table, call, wide mode, level}; exp is {gp, np, commit, switch, level}.
    task automatic xfer(input string nm, input logic [4:0] m, input logic [15:0] sel, input logic [63:0] lo,
        input logic [63:0] hi, input logic [63:0] dst, input logic [5:0] exp);
        int n;
        @(negedge mclk_in);
        req <= '{m[3], m[2], m[1:0], sel, 64'hdead_beef_0bad_f00d, m[4], lo, hi, dst};
        go <= 1'b1;
        @(negedge mclk_in);
        go <= 1'b0;
        for (n = 0; n < 4 && done !== 1'b1; n++) @(negedge mclk_in);
        chk(nm, 64'h1, {63'h0, done});
        chk(nm, {58'h0, exp}, {58'h0, res.general_protection_fault, res.not_present_fault, res.commit,
            res.stack_switch, res.current_priv_level});
        $display("%s done", nm);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #20us;
        error_cnt++;
        final_report();
    end
    initial begin
        repeat (12) @(posedge mclk_in);
        @(negedge mclk_in);
        rst_n_in <= 1'b1;
        xfer("conf_rpl0", 5'h0b, 16'h0030, code(2'h0, 1'b1, 1'b0), 64'h0, 64'h0, 6'h0b);
        xfer("conf_rpl3", 5'h0b, 16'h0033, code(2'h0, 1'b1, 1'b0), 64'h0, 64'h0, 6'h0b);
        xfer("conf_low", 5'h09, 16'h0030, code(2'h2, 1'b1, 1'b0), 64'h0, 64'h0, 6'h21);
        xfer("direct_eq", 5'h02, 16'h0032, code(2'h2, 1'b0, 1'b0), 64'h0, 64'h0, 6'h0a);
        xfer("direct_up", 5'h0a, 16'h0032, code(2'h1, 1'b0, 1'b0), 64'h0, 64'h0, 6'h22);
        chk("code_sel", 64'h32, res.code_sel);
        xfer("gate_idt", 5'h1b, 16'h0040, gate(4'hc, 2'h3, 1'b1), 64'h0, code(2'h0, 1'b0, 1'b0), 6'h23);
        xfer("gate_cpl", 5'h0b, 16'h0040, gate(4'hc, 2'h2, 1'b1), 64'h0, code(2'h0, 1'b0, 1'b0), 6'h23);
        xfer("gate_np", 5'h0b, 16'h0040, gate(4'hc, 2'h3, 1'b0), 64'h0, code(2'h0, 1'b0, 1'b0), 6'h13);
        xfer("gate_jmp", 5'h03, 16'h0040, gate(4'hc, 2'h3, 1'b1), 64'h0, code(2'h0, 1'b0, 1'b0), 6'h23);
        xfer("gate_call", 5'h0b, 16'h0040, gate(4'hc, 2'h3, 1'b1), 64'h0, code(2'h0, 1'b0, 1'b0), 6'h0c);
        chk("params", 64'h5, res.param_count);
        chk("entry", 64'h1340, res.entry_addr);
        chk("code_sel", 64'h28, res.code_sel);
        chk("push", gate_check_pkg::PUSH_4, res.push_size);
        xfer("gate16", 5'h0b, 16'h0040, gate(4'h4, 2'h3, 1'b1), 64'h0, code(2'h0, 1'b0, 1'b0), 6'h0c);
        chk("push", gate_check_pkg::PUSH_2, res.push_size);
        xfer("wide", 5'h0f, 16'h0040, gate(4'hc, 2'h3, 1'b1), 64'h0, code(2'h0, 1'b0, 1'b1), 6'h0c);
        chk("push", gate_check_pkg::PUSH_8, res.push_size);
        chk("params", 64'h0, res.param_count);
        chk("entry", 64'h1340, res.entry_addr);
        xfer("wide_canon", 5'h0f, 16'h0040, gate(4'hc, 2'h3, 1'b1), 64'h1_0000, code(2'h0, 1'b0, 1'b1), 6'h23);
        xfer("wide_type", 5'h0f, 16'h0040, gate(4'hc, 2'h3, 1'b1), 64'h100_0000_0000, code(2'h0, 1'b0, 1'b1), 6'h23);
        xfer("wide_long", 5'h0f, 16'h0040, gate(4'hc, 2'h3, 1'b1), 64'h0, code(2'h0, 1'b0, 1'b0), 6'h23);
        chk("fault_sel", 64'h28, res.fault_sel);
        xfer("wide_16", 5'h0f, 16'h0040, gate(4'h4, 2'h3, 1'b1), 64'h0, code(2'h0, 1'b0, 1'b1), 6'h23);
        final_report();
    end
endmodule
`default_nettype wire
